/* File: include/drts_map.svh */
// register map, field positions, reset values and timing figures
// assumes a single 100 MHz clock and a command-code register port
`ifndef DRTS_MAP_SVH
`define DRTS_MAP_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define DRTS_CMD_STATUS 8'h02
`define DRTS_CMD_CONFIG 8'h03
`define DRTS_CMD_FILTER 8'h06
`define DRTS_CMD_MODEL 8'h30
`define DRTS_CMD_ONESHOT 8'h0F
`define DRTS_CMD_HI_A 8'h11
`define DRTS_CMD_HI_B 8'h12
`define DRTS_CMD_LO_A 8'h21
`define DRTS_CMD_LO_B 8'h22

// ----------------------------------------------------------------
// fields, masks and reset values
// ----------------------------------------------------------------
`define DRTS_CFG_STANDBY 6
`define DRTS_CFG_RATE_HI 5
`define DRTS_CFG_RATE_LO 4
`define DRTS_CFG_FMT_B 2
`define DRTS_CFG_FMT_A 1
`define DRTS_CFG_WMASK 8'h76
`define DRTS_CFG_RESET 8'h00
`define DRTS_CH_B_BIT 2
`define DRTS_CH_A_BIT 0
`define DRTS_CH_WMASK 8'h05
`define DRTS_FILT_RESET 8'h05
`define DRTS_MODEL_RESET 8'h01
`define DRTS_FORCE_UNSIGNED 16'hFFE0
`define DRTS_FORCE_SIGNED 16'h8000
`define DRTS_LO_MASK_FILT 8'hF8
`define DRTS_LO_MASK_RAW 8'hE0

// ----------------------------------------------------------------
// clock in MHz, timing in microseconds
// ----------------------------------------------------------------
`define DRTS_CLK_MHZ 100
`define DRTS_TICK_US 1
`define DRTS_T_CONV_US 76500
`define DRTS_T_CONV_ENH_US 77800
`define DRTS_T_PER1_US 182000
`define DRTS_T_PER2_US 1000000
`define DRTS_T_PER3_US 2700000

`endif

/* File: include/drts_pkg.sv */
// state types shared by the control, timer and result modules
// assumes drts_map.svh supplies all numeric constants
`default_nettype none
package drts_pkg;
    typedef enum logic [1:0] {DRTS_IDLE, DRTS_CONV, DRTS_WAIT} drts_phase_e;

    typedef struct packed {
        drts_phase_e phase;
        logic [6:0] div;
        logic [21:0] cnt;
    } drts_tmr_s;

    typedef struct packed {
        logic [15:0] value;
        logic [7:0] lo_lock;
        logic locked;
    } drts_res_s;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] cfg;
        logic [7:0] filt;
        logic [7:0] model;
        logic enh_a;
        logic enh_b;
        logic abs_a;
        logic abs_b;
        logic [7:0] rdata;
    } drts_ctl_s;
endpackage
`default_nettype wire

/* File: include/drts_if.sv */
// carriers between control, conversion timer and result latches
// assumes all parties share one clock
`timescale 1ns/100ps
`default_nettype none
interface drts_conv_if;
    logic run;
    logic oneshot;
    logic [1:0] rate;
    logic enh_any;
    logic busy;
    logic start;
    logic done;
    modport ctl (output run, output oneshot, output rate, output enh_any,
                 input busy, input start, input done);
    modport tmr (input run, input oneshot, input rate, input enh_any,
                 output busy, output start, output done);
endinterface

interface drts_res_if;
    logic done;
    logic absent;
    logic signed_fmt;
    logic filter_on;
    logic [15:0] raw;
    logic rd_hi;
    logic rd_lo;
    logic [7:0] hi_byte;
    logic [7:0] lo_byte;
    modport ctl (output done, output absent, output signed_fmt, output filter_on,
                 output raw, output rd_hi, output rd_lo, input hi_byte, input lo_byte);
    modport res (input done, input absent, input signed_fmt, input filter_on,
                 input raw, input rd_hi, input rd_lo, output hi_byte, output lo_byte);
endinterface
`default_nettype wire

/* File: verilog/drts_conv_timer.sv */
// conversion scheduler: busy window and interval spacing
// assumes run/oneshot/rate come from the control register block
`timescale 1ns/100ps
`default_nettype none
`include "drts_map.svh"
module drts_conv_timer
    import drts_pkg::*;
#(
    parameter int T_CONV_US = `DRTS_T_CONV_US,
    parameter int T_CONV_ENH_US = `DRTS_T_CONV_ENH_US,
    parameter int T_PER1_US = `DRTS_T_PER1_US,
    parameter int T_PER2_US = `DRTS_T_PER2_US,
    parameter int T_PER3_US = `DRTS_T_PER3_US
) (
    input wire logic clock,
    input wire logic rst_n,
    drts_conv_if.tmr cv
);
    // ----------------------------------------------------------------
    // constants and checks
    // ----------------------------------------------------------------
    localparam int TICK_CYC = `DRTS_CLK_MHZ * `DRTS_TICK_US;
    localparam logic [6:0] DIV_END = 7'(TICK_CYC - 1);
    localparam logic [21:0] E_CONV = 22'(T_CONV_US - 1);
    localparam logic [21:0] E_ENH = 22'(T_CONV_ENH_US - 1);
    localparam logic [21:0] E_P1 = 22'(T_PER1_US - 1);
    localparam logic [21:0] E_P2 = 22'(T_PER2_US - 1);
    localparam logic [21:0] E_P3 = 22'(T_PER3_US - 1);

    if (TICK_CYC < 1 || TICK_CYC > 128) begin : g_bad_tick
        $error("tick divider out of range");
    end
    if (T_CONV_US < 1 || T_CONV_ENH_US < 1 || T_PER3_US >= (1 << 22)) begin : g_bad_cnt
        $error("conversion timing does not fit the counter");
    end
    if (T_PER1_US <= T_CONV_ENH_US || T_PER2_US <= T_CONV_ENH_US) begin : g_bad_per
        $error("interval shorter than a conversion");
    end

    // ----------------------------------------------------------------
    // scheduler
    // ----------------------------------------------------------------
    drts_tmr_s q;
    drts_tmr_s d;
    logic tick;
    logic start;
    logic done;
    logic [21:0] conv_end;
    logic [21:0] per_end;

    // enhanced conversions run longer, so the back-to-back period at rate 00 stretches
    assign conv_end = cv.enh_any ? E_ENH : E_CONV;

    always_comb begin
        case (cv.rate)
            2'b01: per_end = E_P1;
            2'b10: per_end = E_P2;
            default: per_end = E_P3;
        endcase
    end

    always_comb begin
        d = q;
        start = 1'b0;
        done = 1'b0;
        tick = (q.div == DIV_END);
        d.div = tick ? 7'h00 : q.div + 7'h01;
        case (q.phase)
            DRTS_IDLE: begin
                if (cv.run || cv.oneshot) begin
                    d.phase = DRTS_CONV;
                    d.cnt = '0;
                    start = 1'b1;
                end
            end
            DRTS_CONV: begin
                if (tick) begin
                    if (q.cnt >= conv_end) begin
                        done = 1'b1;
                        if (cv.run && cv.rate == 2'b00) begin
                            d.cnt = '0;
                            start = 1'b1;
                        end else if (cv.run) begin
                            d.phase = DRTS_WAIT;
                            d.cnt = q.cnt + 22'h000001;
                        end else begin
                            // a one-shot or a late standby ends here
                            d.phase = DRTS_IDLE;
                        end
                    end else begin
                        d.cnt = q.cnt + 22'h000001;
                    end
                end
            end
            DRTS_WAIT: begin
                if (!cv.run) begin
                    d.phase = DRTS_IDLE;
                end else if (tick) begin
                    if (q.cnt >= per_end) begin
                        d.phase = DRTS_CONV;
                        d.cnt = '0;
                        start = 1'b1;
                    end else begin
                        d.cnt = q.cnt + 22'h000001;
                    end
                end
            end
            default: d.phase = DRTS_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{phase: DRTS_IDLE, div: 7'h00, cnt: 22'h000000};
        end else begin
            q <= d;
        end
    end

    assign cv.busy = (q.phase == DRTS_CONV);
    assign cv.start = start;
    assign cv.done = done;
endmodule // drts_conv_timer
`default_nettype wire

/* File: verilog/drts_result_latch.sv */
// one remote channel result with forced fault codes and low-byte lock
// assumes done pulses once per finished conversion
`timescale 1ns/100ps
`default_nettype none
`include "drts_map.svh"
module drts_result_latch
    import drts_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    drts_res_if.res rs
);
    drts_res_s q;
    drts_res_s d;
    logic [7:0] lo_now;

    // unfiltered results carry fewer fraction bits
    assign lo_now = q.value[7:0]
        & (rs.filter_on ? `DRTS_LO_MASK_FILT : `DRTS_LO_MASK_RAW);

    always_comb begin
        d = q;
        if (rs.done) begin
            if (rs.absent) begin
                d.value = rs.signed_fmt ? `DRTS_FORCE_SIGNED
                    : `DRTS_FORCE_UNSIGNED;
            end else begin
                d.value = rs.raw;
            end
        end
        // hi read in the same cycle as done locks the old pair, matching its hi byte
        if (rs.rd_hi) begin
            d.lo_lock = lo_now;
            d.locked = 1'b1;
        end else if (rs.rd_lo) begin
            d.locked = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{value: 16'h0000, lo_lock: 8'h00, locked: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign rs.hi_byte = q.value[15:8];
    assign rs.lo_byte = q.locked ? q.lo_lock : lo_now;
endmodule // drts_result_latch
`default_nettype wire

/* File: verilog/drts_ctrl.sv */
// control and status registers of the dual remote sensor readout
// assumes a bus front end that turns frames into cmd_set/cmd_wr/cmd_rd pulses
`timescale 1ns/100ps
`default_nettype none
`include "drts_map.svh"
module drts_ctrl
    import drts_pkg::*;
#(
    parameter int T_CONV_US = `DRTS_T_CONV_US,
    parameter int T_CONV_ENH_US = `DRTS_T_CONV_ENH_US,
    parameter int T_PER1_US = `DRTS_T_PER1_US,
    parameter int T_PER2_US = `DRTS_T_PER2_US,
    parameter int T_PER3_US = `DRTS_T_PER3_US
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_set,
    input wire logic cmd_wr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata,
    input wire logic enh_req_a,
    input wire logic enh_req_b,
    input wire logic diode_absent_a,
    input wire logic diode_absent_b,
    input wire logic [15:0] raw_a,
    input wire logic [15:0] raw_b,
    output logic conv_start,
    output logic conv_done,
    output logic conv_busy,
    output logic standby,
    output logic remote_a_enhanced_active,
    output logic remote_b_enhanced_active,
    output logic remote_a_format,
    output logic remote_b_format,
    output logic remote_a_filter_on,
    output logic remote_b_filter_on,
    output logic remote_a_model,
    output logic remote_b_model
);
    // ----------------------------------------------------------------
    // sub-blocks
    // ----------------------------------------------------------------
    drts_ctl_s q;
    drts_ctl_s d;
    drts_conv_if cv ();
    drts_res_if rs [2] ();

    logic [1:0][15:0] raw_v;
    logic [1:0] absent_v;
    logic [1:0] fmt_v;
    logic [1:0] filt_v;
    logic [1:0] rd_hi_v;
    logic [1:0] rd_lo_v;
    logic wr_oneshot;
    logic [7:0] status;

    drts_conv_timer #(
        .T_CONV_US(T_CONV_US),
        .T_CONV_ENH_US(T_CONV_ENH_US),
        .T_PER1_US(T_PER1_US),
        .T_PER2_US(T_PER2_US),
        .T_PER3_US(T_PER3_US)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .cv(cv)
    );

    assign raw_v = {raw_b, raw_a};
    assign absent_v = {diode_absent_b, diode_absent_a};
    assign fmt_v = {q.cfg[`DRTS_CFG_FMT_B], q.cfg[`DRTS_CFG_FMT_A]};
    assign filt_v = {q.filt[`DRTS_CH_B_BIT], q.filt[`DRTS_CH_A_BIT]};
    assign rd_hi_v = {cmd_rd && q.ptr == `DRTS_CMD_HI_B, cmd_rd && q.ptr == `DRTS_CMD_HI_A};
    assign rd_lo_v = {cmd_rd && q.ptr == `DRTS_CMD_LO_B, cmd_rd && q.ptr == `DRTS_CMD_LO_A};

    for (genvar g = 0; g < 2; g++) begin : g_ch
        assign rs[g].done = cv.done;
        assign rs[g].absent = absent_v[g];
        assign rs[g].signed_fmt = fmt_v[g];
        assign rs[g].filter_on = filt_v[g];
        assign rs[g].raw = raw_v[g];
        assign rs[g].rd_hi = rd_hi_v[g];
        assign rs[g].rd_lo = rd_lo_v[g];
        drts_result_latch u_res (
            .clock(clock),
            .rst_n(rst_n),
            .rs(rs[g])
        );
    end

    // ----------------------------------------------------------------
    // conversion control
    // ----------------------------------------------------------------
    // one-shot has no storage; only the write itself matters
    assign wr_oneshot = cmd_wr && q.ptr == `DRTS_CMD_ONESHOT;
    assign cv.run = !q.cfg[`DRTS_CFG_STANDBY];
    assign cv.oneshot = wr_oneshot && q.cfg[`DRTS_CFG_STANDBY];
    assign cv.rate = {q.cfg[`DRTS_CFG_RATE_HI], q.cfg[`DRTS_CFG_RATE_LO]};
    assign cv.enh_any = q.enh_a || q.enh_b;

    assign status = {cv.busy, 3'b000, q.enh_b, q.enh_a, q.abs_b, q.abs_a};

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        if (cmd_set) begin
            d.ptr = cmd_code;
        end
        if (cmd_wr) begin
            case (q.ptr)
                `DRTS_CMD_CONFIG: d.cfg = cmd_wdata & `DRTS_CFG_WMASK;
                `DRTS_CMD_FILTER: d.filt = cmd_wdata & `DRTS_CH_WMASK;
                `DRTS_CMD_MODEL: d.model = cmd_wdata & `DRTS_CH_WMASK;
                default: d.cfg = q.cfg;
            endcase
        end
        // a request is taken up at a conversion start or while idle, so it is
        // never more than one conversion late
        if (cv.start || !cv.busy) begin
            d.enh_a = enh_req_a;
            d.enh_b = enh_req_b;
        end
        // the front end may also report a discrete transistor as absent
        // when enhanced mode is on; that report is passed through as is
        if (cv.done) begin
            d.abs_a = diode_absent_a;
            d.abs_b = diode_absent_b;
        end
        if (cmd_rd) begin
            case (q.ptr)
                `DRTS_CMD_STATUS: d.rdata = status;
                `DRTS_CMD_CONFIG: d.rdata = q.cfg;
                `DRTS_CMD_FILTER: d.rdata = q.filt;
                `DRTS_CMD_MODEL: d.rdata = q.model;
                `DRTS_CMD_ONESHOT: d.rdata = 8'h00;
                `DRTS_CMD_HI_A: d.rdata = rs[0].hi_byte;
                `DRTS_CMD_HI_B: d.rdata = rs[1].hi_byte;
                `DRTS_CMD_LO_A: d.rdata = rs[0].lo_byte;
                `DRTS_CMD_LO_B: d.rdata = rs[1].lo_byte;
                default: d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{
                ptr: 8'h00,
                cfg: `DRTS_CFG_RESET,
                filt: `DRTS_FILT_RESET,
                model: `DRTS_MODEL_RESET,
                enh_a: 1'b0,
                enh_b: 1'b0,
                abs_a: 1'b0,
                abs_b: 1'b0,
                rdata: 8'h00
            };
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cmd_rdata = q.rdata;
    assign conv_start = cv.start;
    assign conv_done = cv.done;
    assign conv_busy = cv.busy;
    assign standby = q.cfg[`DRTS_CFG_STANDBY];
    assign remote_a_enhanced_active = q.enh_a;
    assign remote_b_enhanced_active = q.enh_b;
    assign remote_a_format = fmt_v[0];
    assign remote_b_format = fmt_v[1];
    assign remote_a_filter_on = filt_v[0];
    assign remote_b_filter_on = filt_v[1];
    // host keeps the enhanced request consistent with the model chosen
    assign remote_a_model = q.model[`DRTS_CH_A_BIT];
    assign remote_b_model = q.model[`DRTS_CH_B_BIT];
endmodule // drts_ctrl
`default_nettype wire

/* File: verif/drts_ctrl_chk.sv */
// checker for the command-code register port and conversion control
// assumes it is bound to drts_ctrl and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module drts_ctrl_chk #(
    parameter int T_CONV_US = 5,
    parameter int T_CONV_ENH_US = 6
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_set,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic [7:0] cmd_rdata,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic conv_busy,
    input wire logic standby,
    input wire logic remote_a_enhanced_active,
    input wire logic remote_b_enhanced_active,
    input wire logic remote_a_format,
    input wire logic remote_b_format,
    input wire logic remote_a_filter_on,
    input wire logic remote_b_filter_on,
    input wire logic remote_a_model,
    input wire logic remote_b_model
);
    // ----------------------------------------------------------------
    // pointer tracking
    // ----------------------------------------------------------------
    // window allows the one-microsecond tick jitter at both ends
    localparam int DONE_MIN = T_CONV_US * 100 - 110;
    localparam int DONE_MAX = T_CONV_ENH_US * 100 + 110;
    logic [7:0] ptr_q;
    logic [7:0] rptr_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= 8'h00;
            rptr_q <= 8'h00;
        end else begin
            if (cmd_rd) begin
                rptr_q <= ptr_q;
            end
            if (cmd_set) begin
                ptr_q <= cmd_code;
            end
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    busy_after_start_a: assert property (conv_start |=> conv_busy)
        else $error("busy did not follow conversion start");
    status_busy_bit_a: assert property ($past(cmd_rd) && rptr_q == 8'h02
        |-> cmd_rdata[7] == $past(conv_busy)) else $error("status busy bit wrong");
    status_rsvd_zero_a: assert property ($past(cmd_rd) && rptr_q == 8'h02
        |-> cmd_rdata[6:4] == 3'h0) else $error("status reserved bits set");
    status_enh_bits_a: assert property ($past(cmd_rd) && rptr_q == 8'h02
        |-> cmd_rdata[3:2] == {$past(remote_b_enhanced_active), $past(remote_a_enhanced_active)})
        else $error("status enhanced bits wrong");
    cfg_read_match_a: assert property ($past(cmd_rd) && rptr_q == 8'h03
        |-> {cmd_rdata[7:6], cmd_rdata[3:0]} == {1'b0, $past(standby), 1'b0,
        $past(remote_b_format), $past(remote_a_format), 1'b0}) else $error("config read wrong");
    filt_read_match_a: assert property ($past(cmd_rd) && rptr_q == 8'h06
        |-> cmd_rdata == {5'h00, $past(remote_b_filter_on), 1'b0, $past(remote_a_filter_on)})
        else $error("filter read wrong");
    model_read_match_a: assert property ($past(cmd_rd) && rptr_q == 8'h30
        |-> cmd_rdata == {5'h00, $past(remote_b_model), 1'b0, $past(remote_a_model)})
        else $error("model read wrong");
    oneshot_reads_zero_a: assert property ($past(cmd_rd) && rptr_q == 8'h0F
        |-> cmd_rdata == 8'h00) else $error("one-shot read not zero");
    standby_no_start_a: assert property (standby && !cmd_wr |-> !conv_start)
        else $error("conversion started in standby");
    oneshot_start_a: assert property (standby && !conv_busy && cmd_wr && ptr_q == 8'h0F
        |-> conv_start ##1 conv_busy) else $error("one-shot did not start");
    done_in_window_a: assert property (conv_start
        |-> ##[DONE_MIN:DONE_MAX] conv_done) else $error("conversion length out of range");
    standby_goes_idle_a: assert property (conv_done && standby |=> !conv_busy)
        else $error("busy after last conversion in standby");
    cover property (standby && cmd_wr && ptr_q == 8'h0F);
    cover property ($past(cmd_rd) && rptr_q == 8'h21);
    cover property (conv_done && !standby);
endmodule // drts_ctrl_chk

bind drts_ctrl drts_ctrl_chk #(.T_CONV_US(T_CONV_US), .T_CONV_ENH_US(T_CONV_ENH_US)) u_chk (
    .clock(clock), .rst_n(rst_n), .cmd_code(cmd_code), .cmd_set(cmd_set), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .conv_start(conv_start), .conv_done(conv_done),
    .conv_busy(conv_busy), .standby(standby),
    .remote_a_enhanced_active(remote_a_enhanced_active),
    .remote_b_enhanced_active(remote_b_enhanced_active),
    .remote_a_format(remote_a_format), .remote_b_format(remote_b_format),
    .remote_a_filter_on(remote_a_filter_on), .remote_b_filter_on(remote_b_filter_on),
    .remote_a_model(remote_a_model), .remote_b_model(remote_b_model));
`default_nettype wire

/* File: verif/drts_fe_model.sv */
// front-end model: remote readings and absence reports per channel
// assumes the controller samples them only in its conv_done cycle
`timescale 1ns/100ps
`default_nettype none
module drts_fe_model (
    input wire logic conv_done,
    input wire logic [15:0] val_a,
    input wire logic [15:0] val_b,
    input wire logic miss_a,
    input wire logic miss_b,
    output logic [15:0] raw_a,
    output logic [15:0] raw_b,
    output logic diode_absent_a,
    output logic diode_absent_b
);
    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // inverse outside the end cycle, so early or late capture shows
    always_comb begin
        raw_a = conv_done ? val_a : ~val_a;
        raw_b = conv_done ? val_b : ~val_b;
        diode_absent_a = conv_done ? miss_a : ~miss_a;
        diode_absent_b = conv_done ? miss_b : ~miss_b;
    end
endmodule // drts_fe_model
`default_nettype wire

/* File: verif/dual_remote_temp_sensor_ctrl_status_tb_top.sv */
// self-checking bench for the control and status register block
// assumes shortened conversion figures so the run stays small
`timescale 1ns/100ps
`default_nettype none
module dual_remote_temp_sensor_ctrl_status_tb_top;
    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] cmd_code = 8'h00, cmd_wdata = 8'h00, cmd_rdata;
    logic cmd_set = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0, enh_a = 1'b0, enh_b = 1'b0;
    logic miss_a = 1'b0, miss_b = 1'b0, abs_a, abs_b, st, dn, busy, stby;
    logic ea, eb, fa, fb, la, lb, ma, mb;
    logic [15:0] val_a = 16'h0000, val_b = 16'h0000, raw_a, raw_b;
    int miscompares = 0, compares = 0, cyc = 0, starts_n = 0;
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (st === 1'b1) begin
            starts_n <= starts_n + 1;
        end
    end
    drts_fe_model fe (.conv_done(dn), .val_a(val_a), .val_b(val_b), .miss_a(miss_a),
        .miss_b(miss_b), .raw_a(raw_a), .raw_b(raw_b), .diode_absent_a(abs_a),
        .diode_absent_b(abs_b));
    drts_ctrl #(.T_CONV_US(5), .T_CONV_ENH_US(6), .T_PER1_US(20), .T_PER2_US(30),
        .T_PER3_US(40)) dut (.clock(clock), .rst_n(rst_n), .cmd_code(cmd_code),
        .cmd_set(cmd_set), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata), .enh_req_a(enh_a), .enh_req_b(enh_b),
        .diode_absent_a(abs_a), .diode_absent_b(abs_b), .raw_a(raw_a), .raw_b(raw_b),
        .conv_start(st), .conv_done(dn), .conv_busy(busy), .standby(stby),
        .remote_a_enhanced_active(ea), .remote_b_enhanced_active(eb),
        .remote_a_format(la), .remote_b_format(lb), .remote_a_filter_on(fa),
        .remote_b_filter_on(fb), .remote_a_model(ma), .remote_b_model(mb));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic setp(input logic [7:0] c);
        @(posedge clock);
        cmd_set <= 1'b1;
        cmd_code <= c;
        @(posedge clock);
        cmd_set <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        setp(c);
        cmd_wr <= 1'b1;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] c, input logic [7:0] exp);
        setp(c);
        cmd_rd <= 1'b1;
        @(posedge clock);
        cmd_rd <= 1'b0;
        @(posedge clock);
        chk(cmd_rdata, exp);
    endtask
    // bounded wait for a start or end pulse, cycle number returned
    task automatic wait_ev(input bit done_ev, output int at);
        for (int n = 0; n < 5000; n++) begin
            @(posedge clock);
            if ((done_ev ? dn : st) === 1'b1) begin
                at = cyc;
                return;
            end
        end
        miscompares++;
        conclude();
    endtask
    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        int t0, t1, t2;
        logic [7:0] cf [5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h00};
        int us [5] = '{5, 20, 30, 40, 6};
        repeat (20) @(posedge clock);
        chk({stby, lb, la, fb, fa, mb, ma, 1'b0}, 8'h1A);
        rst_n <= 1'b1;
        rdchk(8'h02, 8'h80);
        rdchk(8'h03, 8'h00);
        rdchk(8'h06, 8'h05);
        rdchk(8'h30, 8'h01);
        rdchk(8'h0F, 8'h00);
        wr(8'h03, 8'hFF);
        rdchk(8'h03, 8'h76);
        wr(8'h06, 8'hFF);
        rdchk(8'h06, 8'h05);
        wr(8'h30, 8'hFF);
        rdchk(8'h30, 8'h05);
        chk({stby, lb, la, fb, fa, mb, ma, 1'b0}, 8'hFE);
        wr(8'h06, 8'h00);
        wr(8'h30, 8'h00);
        wr(8'h02, 8'hFF);
        wr(8'h55, 8'hFF);
        rdchk(8'h55, 8'h00);
        rdchk(8'h03, 8'h76);
        chk({stby, lb, la, fb, fa, mb, ma, 1'b0}, 8'hE0);
        wait_ev(1'b1, t0);
        t1 = starts_n;
        repeat (1000) @(posedge clock);
        chk(8'(starts_n - t1), 8'h00);
        // absent diode here stands in for the enhanced-mode false flag too
        miss_a <= 1'b1;
        enh_a <= 1'b1;
        enh_b <= 1'b1;
        val_b <= 16'h1234;
        wr(8'h0F, 8'hA5);
        wait_ev(1'b1, t0);
        rdchk(8'h02, 8'h0D);
        chk({6'h00, eb, ea}, 8'h03);
        chk(8'(starts_n - t1), 8'h01);
        rdchk(8'h11, 8'h80);
        rdchk(8'h21, 8'h00);
        rdchk(8'h12, 8'h12);
        rdchk(8'h22, 8'h20);
        wr(8'h03, 8'h40);
        wr(8'h0F, 8'h00);
        wait_ev(1'b1, t0);
        rdchk(8'h11, 8'hFF);
        rdchk(8'h21, 8'hE0);
        miss_a <= 1'b0;
        val_a <= 16'h5678;
        wr(8'h06, 8'h05);
        wr(8'h0F, 8'h00);
        wait_ev(1'b1, t0);
        rdchk(8'h02, 8'h0C);
        rdchk(8'h11, 8'h56);
        @(posedge clock);
        val_a <= 16'h9ABC;
        wr(8'h0F, 8'h00);
        wait_ev(1'b1, t0);
        rdchk(8'h21, 8'h78);
        rdchk(8'h21, 8'hB8);
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            enh_a <= (i == 4);
            enh_b <= 1'b0;
            wr(8'h03, cf[i]);
            wait_ev(1'b0, t0);
            wait_ev(1'b0, t1);
            wait_ev(1'b0, t2);
            t2 = t2 - t1;
            chk(8'(t2 >= us[i] * 100 - 110 && t2 <= us[i] * 100 + 110), 8'h01);
        end
        conclude();
    end
endmodule // dual_remote_temp_sensor_ctrl_status_tb_top
`default_nettype wire
